// ### inc/dalrl_pkg.sv
// Package for the dual-input alarm and relay logic: map, fields, encodings
package dalrl_pkg;
    localparam int RW = 32;  // Reading and setpoint width, signed
    localparam int NIN = 2;  // Inputs
    localparam int NRLY = 2; // Relays
    localparam int NSRC = 4; // Reading sources per input
    localparam int SRCW = 2;

    // Register byte offsets (APB)
    localparam logic [11:0] OFS_GLOBAL  = 12'h000; // audible, clear
    localparam logic [11:0] OFS_RLY     = 12'h004; // relay assignments
    localparam logic [11:0] OFS_STATUS  = 12'h008; // alarm/relay states, RO
    localparam logic [11:0] OFS_IN_BASE = 12'h010; // per-input block base
    localparam logic [11:0] OFS_IN_STEP = 12'h010; // per-input block stride
    localparam logic [3:0]  OFS_CFG     = 4'h0;    // within block
    localparam logic [3:0]  OFS_LOW     = 4'h4;
    localparam logic [3:0]  OFS_HIGH    = 4'h8;
    localparam logic [3:0]  OFS_BAND    = 4'hc;

    // Input config fields
    localparam int CFG_EN    = 0;
    localparam int CFG_LATCH = 1;
    localparam int CFG_SRC   = 4;  // two bits
    // Global fields
    localparam int GL_AUDIBLE = 0;
    localparam int GL_CLEAR   = 1; // write one: alarm-key clear
    // Relay field layout: per relay 4 bits at 8*relay
    localparam int RL_STRIDE = 8;
    localparam int RL_MODE   = 0;  // two bits
    localparam int RL_FUNC   = 2;  // two bits
    // Status layout: per input hi,lo at 2*i; relays at 4
    localparam int ST_RLY = 4;

    // Flash period of annunciator, half-period in ms
    localparam int CLK_HZ     = 40_000_000;
    localparam int FLASH_MS   = 250;
    localparam int FLASH_CYC  = CLK_HZ / 1000 * FLASH_MS;
    localparam int FLASH_W    = 24;

    typedef enum logic [1:0] {
        SRC_CELSIUS, SRC_KELVIN, SRC_LINEAR, SRC_SENSOR
    } dalrl_src_type;
    typedef enum logic [1:0] {
        RMODE_OFF, RMODE_ON, RMODE_IN_A, RMODE_IN_B
    } dalrl_rmode_type;
    typedef enum logic [1:0] {
        RFUNC_BOTH, RFUNC_LOW, RFUNC_HIGH, RFUNC_RSVD
    } dalrl_rfunc_type;

    localparam logic [RW-1:0] ZERO_W   = 32'h0000_0000;
    localparam logic [7:0]    CFG_RST  = 8'h00;
    localparam logic [15:0]   RLY_RST  = 16'h0000;
endpackage : dalrl_pkg

// ### core/dalrl_top.sv
// Alarm evaluation and relay steering for two inputs, APB slave
// Contract
// - Each input has independent high and low limit checks with setpoints.
// - High alarm asserts when selected reading exceeds high setpoint.
// - Low alarm asserts when selected reading falls below low setpoint.
// - Each input selects Celsius, kelvin, linear or sensor reading.
// - Per-input enable; disabled input takes no part in alarms.
// - Annunciator steady when any enabled, flashes when any active.
// - Annunciator reflects all inputs regardless of display.
// - Global audible setting sounds beeper while any alarm active.
// - Latching alarms stay asserted after condition clears.
// - Alarm-clear action clears all latched alarms.
// - Non-latching alarms track the reading with dead band.
// - High alarm releases at setpoint minus dead band.
// - Low alarm releases at setpoint plus the same dead band.
// - Two relays, each independently configured the same way.
// - Manual off holds relay inactive.
// - Manual on holds relay active.
// - Relay on input A follows only A alarms via its function.
// - Relay on input B follows only B alarms via its function.
// - Both function: relay active on high or low alarm.
// - Low function: relay active exactly on low alarm.
// - High function: relay active exactly on high alarm.
module dalrl_top
    import dalrl_pkg::*;
(
    input  wire logic              pclk,         // 40 MHz clock
    input  wire logic              presetn,      // Async reset, low
    input  wire logic              psel,         // APB select
    input  wire logic              penable,      // APB enable
    input  wire logic              pwrite,       // APB direction
    input  wire logic [11:0]       paddr,        // APB byte address
    input  wire logic [31:0]       pwdata,       // APB write data
    output logic      [31:0]       prdata,       // APB read data
    output logic                   pready,       // APB ready
    output logic                   pslverr,      // APB error
    input  wire logic [NIN-1:0]    rd_valid,     // New reading per input
    input  wire logic [RW-1:0]     rd_celsius_a, // Input A Celsius
    input  wire logic [RW-1:0]     rd_kelvin_a,  // Input A kelvin
    input  wire logic [RW-1:0]     rd_linear_a,  // Input A linear result
    input  wire logic [RW-1:0]     rd_sensor_a,  // Input A sensor units
    input  wire logic [RW-1:0]     rd_celsius_b, // Input B Celsius
    input  wire logic [RW-1:0]     rd_kelvin_b,  // Input B kelvin
    input  wire logic [RW-1:0]     rd_linear_b,  // Input B linear result
    input  wire logic [RW-1:0]     rd_sensor_b,  // Input B sensor units
    input  wire logic              alarm_key,    // Alarm-key clear pulse
    output logic [NIN-1:0]         alarm_high,   // High alarm per input
    output logic [NIN-1:0]         alarm_low,    // Low alarm per input
    output logic [NRLY-1:0]        relay_on,     // Relay active
    output logic                   annunciator,  // Alarm lamp
    output logic                   beeper        // Audible alarm
);

    // Setpoints and settings, one set per input
    logic [7:0]    cfg_q  [NIN];
    logic [RW-1:0] low_q  [NIN];
    logic [RW-1:0] high_q [NIN];
    logic [RW-1:0] band_q [NIN];

    // Shared settings
    logic [15:0]   rly_q;
    logic          audible_q;

    // Clear request, one cycle after key or write
    logic          clear_q;

    // Blink timebase for the lamp
    logic [FLASH_W-1:0] flash_cnt_q;
    logic          flash_q;

    // Alarm state and registered outputs
    logic [NIN-1:0] hi_q, lo_q;
    logic [NRLY-1:0] rly_out_q;
    logic          ann_q, beep_q;

    // Bus answer
    logic [31:0]   prdata_q;
    logic          pready_q, pslverr_q;

    // All sources of both inputs side by side
    logic [RW-1:0] rd_in  [NIN][NSRC];

    // Input A sources
    assign rd_in[0][SRC_CELSIUS] = rd_celsius_a;
    assign rd_in[0][SRC_KELVIN]  = rd_kelvin_a;
    assign rd_in[0][SRC_LINEAR]  = rd_linear_a;
    assign rd_in[0][SRC_SENSOR]  = rd_sensor_a;

    // Input B sources
    assign rd_in[1][SRC_CELSIUS] = rd_celsius_b;
    assign rd_in[1][SRC_KELVIN]  = rd_kelvin_b;
    assign rd_in[1][SRC_LINEAR]  = rd_linear_b;
    assign rd_in[1][SRC_SENSOR]  = rd_sensor_b;

    // True when an address hits register r of input block i
    function automatic logic in_hit(input logic [11:0] a, input int i,
                                    input logic [3:0] r);
        logic [11:0] base;
        base = OFS_IN_BASE + 12'(i) * OFS_IN_STEP;
        return a == base + {8'h00, r};
    endfunction : in_hit

    // Any mapped register; misses answer with an error
    function automatic logic addr_ok(input logic [11:0] a);
        logic ok;
        ok = (a == OFS_GLOBAL) || (a == OFS_RLY) || (a == OFS_STATUS);
        for (int i = 0; i < NIN; i++) begin
            ok = ok || in_hit(a, i, OFS_CFG) || in_hit(a, i, OFS_LOW)
                    || in_hit(a, i, OFS_HIGH) || in_hit(a, i, OFS_BAND);
        end
        return ok;
    endfunction : addr_ok

    logic setup;
    logic wr;

    // Zero-wait slave: answer in the setup cycle's following edge
    assign setup = psel && !penable;

    // Write lands only at the edge that sees ready high
    assign wr    = psel && penable && pwrite && pready_q;


    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !addr_ok(paddr);
        end
    end


    // Read data captured in setup, stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= ZERO_W;
        end else if (setup && !pwrite) begin
            prdata_q <= ZERO_W;
            if (paddr == OFS_GLOBAL)
                prdata_q[GL_AUDIBLE] <= audible_q;
            if (paddr == OFS_RLY)
                prdata_q[15:0] <= rly_q;
            if (paddr == OFS_STATUS) begin
                for (int i = 0; i < NIN; i++) begin
                    prdata_q[2*i]   <= hi_q[i];
                    prdata_q[2*i+1] <= lo_q[i];
                end
                prdata_q[ST_RLY +: NRLY] <= rly_out_q;
            end
            for (int i = 0; i < NIN; i++) begin
                if (in_hit(paddr, i, OFS_CFG))  prdata_q[7:0] <= cfg_q[i];
                if (in_hit(paddr, i, OFS_LOW))  prdata_q <= low_q[i];
                if (in_hit(paddr, i, OFS_HIGH)) prdata_q <= high_q[i];
                if (in_hit(paddr, i, OFS_BAND)) prdata_q <= band_q[i];
            end
        end
    end


    // Clear bit is a strobe; it never reads back as one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            audible_q <= 1'b0;
            rly_q     <= RLY_RST;
            clear_q   <= 1'b0;
        end else begin
            clear_q <= alarm_key ||
                       (wr && paddr == OFS_GLOBAL && pwdata[GL_CLEAR]);
            if (wr && paddr == OFS_GLOBAL)
                audible_q <= pwdata[GL_AUDIBLE];
            if (wr && paddr == OFS_RLY)
                rly_q <= pwdata[15:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_in
            logic en, latch, over, under, hi_rel, lo_rel;
            logic signed [RW-1:0] r, h, l, b;
            assign r  = rd_in[gi][cfg_q[gi][CFG_SRC +: SRCW]];

            // Signed compares: Celsius and linear may go negative
            assign h  = high_q[gi];
            assign l  = low_q[gi];
            assign b  = band_q[gi];

            assign en    = cfg_q[gi][CFG_EN];
            assign latch = cfg_q[gi][CFG_LATCH];

            assign over   = r > h;

            assign under  = r < l;

            assign hi_rel = r <= h - b;

            assign lo_rel = r >= l + b;

            // Setpoint writes; wrapping band is the user's risk

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_q[gi]  <= CFG_RST;
                    low_q[gi]  <= ZERO_W;
                    high_q[gi] <= ZERO_W;
                    band_q[gi] <= ZERO_W;
                end else if (wr) begin
                    if (in_hit(paddr, gi, OFS_CFG))
                        cfg_q[gi] <= pwdata[7:0];
                    if (in_hit(paddr, gi, OFS_LOW))
                        low_q[gi] <= pwdata;
                    if (in_hit(paddr, gi, OFS_HIGH))
                        high_q[gi] <= pwdata;
                    if (in_hit(paddr, gi, OFS_BAND))
                        band_q[gi] <= pwdata;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    hi_q[gi] <= 1'b0;
                    lo_q[gi] <= 1'b0;
                end else if (!en) begin
                    hi_q[gi] <= 1'b0;
                    lo_q[gi] <= 1'b0;
                end else if (rd_valid[gi]) begin
                    if (latch) begin
                        // latch holds; new trip beats clear
                        hi_q[gi] <= over || (hi_q[gi] && !clear_q);
                        lo_q[gi] <= under || (lo_q[gi] && !clear_q);
                    end else begin
                        hi_q[gi] <= over || (hi_q[gi] && !hi_rel);
                        lo_q[gi] <= under || (lo_q[gi] && !lo_rel);
                    end
                end else if (latch && clear_q) begin
                    hi_q[gi] <= 1'b0;
                    lo_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Relay value from its mode, function and both inputs' alarms
    function automatic logic relay_eval(input logic [3:0] c,
                                        input logic [NIN-1:0] hi,
                                        input logic [NIN-1:0] lo);
        logic h, l, v;

        h = 1'b0;
        l = 1'b0;
        v = 1'b0;

        // Mode picks the alarm pair, function picks from it
        unique case (dalrl_rmode_type'(c[RL_MODE +: 2]))
            RMODE_OFF:  v = 1'b0;
            RMODE_ON:   v = 1'b1;
            RMODE_IN_A: begin
                h = hi[0];
                l = lo[0];
            end
            RMODE_IN_B: begin
                h = hi[1];
                l = lo[1];
            end
        endcase
        if (c[RL_MODE +: 2] == RMODE_IN_A || c[RL_MODE +: 2] == RMODE_IN_B)
        begin
            unique case (dalrl_rfunc_type'(c[RL_FUNC +: 2]))
                RFUNC_BOTH: v = h || l;
                RFUNC_LOW:  v = l;
                RFUNC_HIGH: v = h;
                // Reserved code behaves as either limit
                RFUNC_RSVD: v = h || l;
            endcase
        end

        return v;
    endfunction : relay_eval

    logic [NRLY-1:0] rly_d;
    generate
        for (gi = 0; gi < NRLY; gi++) begin : g_rly
            assign rly_d[gi] = relay_eval(rly_q[gi*RL_STRIDE +: 4],
                                          hi_q, lo_q);
        end
    endgenerate


    // Relays registered so no decode glitch reaches a coil
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rly_out_q <= '0;
        else
            rly_out_q <= rly_d;
    end


    // Free-running flash so all inputs blink in phase
    // Phase is not reset by a new alarm; first blink may be short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cnt_q <= '0;
            flash_q     <= 1'b0;
        end else if (flash_cnt_q == FLASH_W'(FLASH_CYC - 1)) begin
            flash_cnt_q <= '0;
            flash_q     <= !flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 1'b1;
        end
    end


    logic any_en;
    logic any_act;

    always_comb begin
        any_en  = 1'b0;
        for (int i = 0; i < NIN; i++)
            any_en = any_en || cfg_q[i][CFG_EN];
    end
    assign any_act = |hi_q || |lo_q;


    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ann_q  <= 1'b0;
            beep_q <= 1'b0;
        end else begin
            ann_q  <= any_act ? flash_q : any_en;
            beep_q <= audible_q && any_act;
        end
    end


    // Every output straight from its flip-flop
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign alarm_high  = hi_q;
    assign alarm_low   = lo_q;
    assign relay_on    = rly_out_q;
    assign annunciator = ann_q;
    assign beeper      = beep_q;

endmodule : dalrl_top

// ### test/dalrl_top_props.sv
// Port-level assertions for the alarm and relay block
module dalrl_top_props
    import dalrl_pkg::*;
(
    input wire logic           pclk,       // Clock
    input wire logic           presetn,    // Async reset, low
    input wire logic           psel,       // APB select
    input wire logic           penable,    // APB enable
    input wire logic           pwrite,     // APB direction
    input wire logic           pready,     // APB ready
    input wire logic           pslverr,    // APB error
    input wire logic [NIN-1:0] rd_valid,   // Reading strobes
    input wire logic           alarm_key,  // Alarm-key pulse
    input wire logic [NIN-1:0] alarm_high, // High alarms
    input wire logic [NIN-1:0] alarm_low,  // Low alarms
    input wire logic           beeper      // Audible alarm
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Clear and disable act up to three edges after their cause
    logic [2:0] cause_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cause_q <= 3'h0;
        else
            cause_q <= {cause_q[1:0],
                        (|rd_valid) | alarm_key | (psel & penable & pwrite)};
    end

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_quiet;
        !(|alarm_high) && !(|alarm_low);
    endsequence

    property p_ready_after_setup;
        s_setup |=> pready && penable;
    endproperty
    a_ready_after_setup:
        assert property (p_ready_after_setup) else $error("no pready");
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    a_ready_in_access:
        assert property (p_ready_in_access) else $error("stray pready");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready:
        assert property (p_err_with_ready) else $error("stray pslverr");
    property p_high_a_trip;
        $rose(alarm_high[0]) |-> $past(rd_valid[0]);
    endproperty
    a_high_a_trip:
        assert property (p_high_a_trip) else $error("high A without reading");
    property p_high_b_trip;
        $rose(alarm_high[1]) |-> $past(rd_valid[1]);
    endproperty
    a_high_b_trip:
        assert property (p_high_b_trip) else $error("high B without reading");
    property p_low_b_trip;
        $rose(alarm_low[1]) |-> $past(rd_valid[1]);
    endproperty
    a_low_b_trip:
        assert property (p_low_b_trip) else $error("low B without reading");
    property p_release_cause;
        $fell(alarm_high[0]) || $fell(alarm_low[1]) |-> |cause_q;
    endproperty
    a_release_cause:
        assert property (p_release_cause) else $error("alarm fell uncaused");
    property p_beep_needs_alarm;
        beeper |-> $past(|{alarm_high, alarm_low});
    endproperty
    a_beep_needs_alarm:
        assert property (p_beep_needs_alarm) else $error("beep without alarm");
    property p_quiet_silent;
        s_quiet |=> !beeper;
    endproperty
    a_quiet_silent:
        assert property (p_quiet_silent) else $error("beep while quiet");
endmodule : dalrl_top_props

bind dalrl_top dalrl_top_props i_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .pslverr(pslverr), .rd_valid(rd_valid), .alarm_key(alarm_key),
    .alarm_high(alarm_high), .alarm_low(alarm_low), .beeper(beeper));

// ### test/dalrl_reading_src.sv
// Reading processor and alarm key model on the block's far side
module dalrl_reading_src
    import dalrl_pkg::*;
(
    input  wire logic      pclk,         // Clock
    output logic [NIN-1:0] rd_valid,     // Reading strobes
    output logic [RW-1:0]  rd_celsius_a, // Input A readings
    output logic [RW-1:0]  rd_kelvin_a,  // Input A
    output logic [RW-1:0]  rd_linear_a,  // Input A
    output logic [RW-1:0]  rd_sensor_a,  // Input A
    output logic [RW-1:0]  rd_celsius_b, // Input B readings
    output logic [RW-1:0]  rd_kelvin_b,  // Input B
    output logic [RW-1:0]  rd_linear_b,  // Input B
    output logic [RW-1:0]  rd_sensor_b,  // Input B
    output logic           alarm_key     // Alarm-key pulse
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rd_valid = '0;
        alarm_key = 1'b0;
        {rd_celsius_a, rd_kelvin_a, rd_linear_a, rd_sensor_a} = '0;
        {rd_celsius_b, rd_kelvin_b, rd_linear_b, rd_sensor_b} = '1;
    end

    task automatic put(input int i, input logic [4*RW-1:0] v);
        if (i == 0)
            {rd_celsius_a, rd_kelvin_a, rd_linear_a, rd_sensor_a} <= v;
        else
            {rd_celsius_b, rd_kelvin_b, rd_linear_b, rd_sensor_b} <= v;
    endtask : put

    // Stale values are inverted so a late sample shows up
    task automatic present(input int i, input logic [4*RW-1:0] v);
        @(posedge pclk);
        put(i, v);
        rd_valid <= NIN'(1) << i;
        @(posedge pclk);
        put(i, ~v);
        rd_valid <= '0;
    endtask : present

    task automatic press_key();
        @(posedge pclk);
        alarm_key <= 1'b1;
        @(posedge pclk);
        alarm_key <= 1'b0;
    endtask : press_key
endmodule : dalrl_reading_src

// ### test/dalrl_top_test.sv
// Self-checking bench for the alarm and relay block
module dalrl_top_test
    import dalrl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rdv;
    logic            alarm_key, annunciator, beeper, err;
    logic [NIN-1:0]  rd_valid, alarm_high, alarm_low;
    logic [NRLY-1:0] relay_on;
    logic [RW-1:0]   rca, rka, rla, rsa, rcb, rkb, rlb, rsb;
    int              fail_count, num_checks, cyc;
    logic [RW-1:0]   tv [7] = '{32'h0000_0064, 32'h0000_0065, 32'h0000_0060,
        32'h0000_005F, 32'h0000_0031, 32'h0000_0036, 32'h0000_0037};
    logic [1:0]      te [7] = '{2'b00, 2'b01, 2'b01, 2'b00, 2'b10, 2'b10, 2'b00};

    dalrl_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rd_valid(rd_valid), .rd_celsius_a(rca), .rd_kelvin_a(rka),
        .rd_linear_a(rla), .rd_sensor_a(rsa), .rd_celsius_b(rcb),
        .rd_kelvin_b(rkb), .rd_linear_b(rlb), .rd_sensor_b(rsb),
        .alarm_key(alarm_key), .alarm_high(alarm_high), .alarm_low(alarm_low),
        .relay_on(relay_on), .annunciator(annunciator), .beeper(beeper));
    dalrl_reading_src i_src (.pclk(pclk), .rd_valid(rd_valid),
        .rd_celsius_a(rca), .rd_kelvin_a(rka), .rd_linear_a(rla),
        .rd_sensor_a(rsa), .rd_celsius_b(rcb), .rd_kelvin_b(rkb),
        .rd_linear_b(rlb), .rd_sensor_b(rsb), .alarm_key(alarm_key));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic conclude();
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [11:0] ia(input int i, input logic [3:0] o);
        return OFS_IN_BASE + OFS_IN_STEP * 12'(i) + {8'h00, o};
    endfunction : ia

    task automatic settle();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("write error", err, 1'b0);
        settle();
    endtask : wr

    task automatic feed(input int i, s, input logic [RW-1:0] v, m);
        logic [4*RW-1:0] x;
        for (int j = 0; j < NSRC; j++)
            x[RW*(NSRC-1-j) +: RW] = (j == s) ? v : m;
        i_src.present(i, x);
        settle();
    endtask : feed

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {fail_count, num_checks, cyc} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", rdv, 32'h0000_0000);
        wr(ia(0, OFS_LOW), 32'h0000_0032);
        wr(ia(0, OFS_HIGH), 32'h0000_0064);
        wr(ia(0, OFS_BAND), 32'h0000_0005);
        wr(ia(1, OFS_LOW), 32'h0000_000A);
        wr(ia(1, OFS_HIGH), 32'h0000_0014);
        wr(ia(1, OFS_BAND), 32'h0000_0002);
        wr(ia(1, OFS_CFG), 32'h0000_0033);
        wr(OFS_RLY, 32'h0000_0B02);
        wr(OFS_GLOBAL, 32'h0000_0001);
        apb(1'b0, ia(1, OFS_HIGH), 32'h0000_0000);
        chk("high b", rdv, 32'h0000_0014);
        for (int s = 0; s < NSRC; s++) begin
            wr(ia(0, OFS_CFG), 32'h0000_0001 | (32'(s) << CFG_SRC));
            feed(0, s, 32'h0000_0065, 32'h0000_004B);
            chk("src trip", alarm_high[0], 1'b1);
            feed(0, s, 32'h0000_004B, 32'h0000_0065);
            chk("src release", alarm_high[0], 1'b0);
        end
        chk("lamp steady", annunciator, 1'b1);
        wr(ia(0, OFS_CFG), 32'h0000_0011);
        for (int n = 0; n < 7; n++) begin
            feed(0, 1, tv[n], 32'h0000_004B);
            chk("alarm a", {alarm_low[0], alarm_high[0]}, te[n]);
            chk("relay 1", relay_on, {1'b0, |te[n]});
            chk("beeper", beeper, |te[n]);
        end
        feed(0, 1, 32'h0000_0065, 32'h0000_004B);
        chk("lamp flash", annunciator, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status", rdv, 32'h0000_0011);
        wr(OFS_RLY, 32'h0000_0100);
        chk("manual", relay_on, 2'b10);
        wr(OFS_RLY, 32'h0000_0001);
        chk("manual", relay_on, 2'b01);
        wr(ia(0, OFS_CFG), 32'h0000_0000);
        chk("disabled a", alarm_high[0], 1'b0);
        chk("lamp b only", annunciator, 1'b1);
        wr(OFS_RLY, 32'h0000_0B00);
        feed(1, 3, 32'h0000_0015, 32'h0000_000F);
        chk("relay 2 high", relay_on, 2'b10);
        feed(1, 3, 32'h0000_000F, 32'h0000_0015);
        chk("latched", alarm_high[1], 1'b1);
        i_src.press_key();
        settle();
        chk("key clear", alarm_high[1], 1'b0);
        feed(1, 3, 32'h0000_0009, 32'h0000_000F);
        chk("high only", relay_on, 2'b00);
        wr(OFS_RLY, 32'h0000_0700);
        feed(1, 3, 32'h0000_0009, 32'h0000_000F);
        chk("low only", relay_on, 2'b10);
        wr(OFS_GLOBAL, 32'h0000_0002);
        chk("reg clear", alarm_low[1], 1'b0);
        feed(1, 3, 32'h0000_0015, 32'h0000_000F);
        chk("mute", beeper, 1'b0);
        wr(ia(1, OFS_CFG), 32'h0000_0000);
        chk("disabled b", alarm_high[1], 1'b0);
        chk("lamp off", annunciator, 1'b0);
        conclude();
    end
endmodule : dalrl_top_test
